// file: dv/asq_core_model.sv
// Converter core model: answers each conversion request after a random delay
`timescale 1ns/1ps
module asq_core_model import asq_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic conv_start,
	input wire asq_conv_s conv_req,
	input wire logic [1:0] lat,
	input wire logic [11:0] res,
	input wire logic fixed,
	output logic conv_done,
	output logic [11:0] conv_result
);
	logic busy_q;
	logic [1:0] cnt_q;
	logic [11:0] val_q;
	////////////////////////////////////////////////////////////////////////////////
	// Result valid only beside done; it toggles otherwise so a stale value never passes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_q <= 1'h0;
			cnt_q <= 2'h0;
			val_q <= 12'h0;
			conv_done <= 1'h0;
			conv_result <= 12'h0;
		end else begin
			conv_done <= 1'h0;
			conv_result <= ~conv_result;
			if (conv_start) begin
				busy_q <= 1'h1;
				cnt_q <= lat;
				// Fixed mode: full scale on step 0 only, so a comparator on its own step misses
				val_q <= fixed ? {12{conv_req.step == 3'h0}} : res;
			end else if (busy_q && cnt_q == 2'h0) begin
				busy_q <= 1'h0;
				conv_done <= 1'h1;
				conv_result <= val_q;
			end else if (busy_q) begin
				cnt_q <= cnt_q - 2'h1;
			end
		end
	end
endmodule // asq_core_model

// file: dv/asq_ctrl_tb_top.sv
// Self-checking bench for the sequencer control block
`timescale 1ns/1ps
`include "asq_cfg.svh"
module asq_ctrl_tb_top import asq_pkg::*; ();
	logic clk, rst_n, reg_wr, reg_rd, trig_ext_pin, global_sync_in, global_sync_out, fixed;
	logic conv_start, conv_done, ref_ext_full, ref_ext_third, irq;
	logic [7:0] reg_addr, pri;
	logic [31:0] reg_wdata, reg_rdata, seed, v;
	logic [1:0] core_lat;
	logic [11:0] conv_result, core_res;
	logic [3:0] dc_trig, p;
	asq_conv_s conv_req;
	int fail_count, samples_checked, gs_cnt, base, s, d0, d1;
	int dc_cnt[4];
	int starts[$];
	int exp_q[$];
	asq_ctrl #(.PHASE_W(8)) i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.trig_comp_pin(1'h0), .trig_ext_pin(trig_ext_pin), .trig_timer_pin(1'h0),
		.trig_pwm_pin(1'h0), .global_sync_in(global_sync_in),
		.global_sync_out(global_sync_out),
		.conv_start(conv_start), .conv_req(conv_req), .conv_done(conv_done),
		.conv_result(conv_result), .ref_ext_full(ref_ext_full),
		.ref_ext_third(ref_ext_third), .dc_trig(dc_trig), .irq(irq));
	asq_core_model i_core (.clk(clk), .rst_n(rst_n), .conv_start(conv_start),
		.conv_req(conv_req), .lat(core_lat), .res(core_res), .fixed(fixed),
		.conv_done(conv_done), .conv_result(conv_result));
	////////////////////////////////////////////////////////////////////////////////
	// Clock at 200 MHz
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	// Reference arbiter, with the third and fourth compared through the second's priority
	function automatic int pick(input logic [3:0] q, input logic [7:0] pr);
		int b;
		b = -1;
		if (q[2] && q[3]) q[(pr[3:2] < pr[5:4]) ? 3 : 2] = 1'h0;
		for (int i = 0; i < 4; i++) if (q[i] && (b < 0 || pr[2*i+:2] < pr[2*b+:2])) b = i;
		return b;
	endfunction
	// Random core timing and results; monitor of starts and pulses
	always @(posedge clk) begin
		seed <= xs(seed);
		core_lat <= seed[1:0];
		core_res <= seed[15:4];
		if (conv_start) starts.push_back(int'(conv_req.seq));
		if (global_sync_out) gs_cnt++;
		for (int i = 0; i < 4; i++) if (dc_trig[i]) dc_cnt[i]++;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Bus write and read; read data land one cycle after the strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'h0;
		// Taken at the edge that closes the data cycle, before the port returns to 0
		@(posedge clk);
		v = reg_rdata;
	endtask
	// Cycles from a processor start to the first conversion, for a given phase offset
	task automatic lat_of(input logic [31:0] ph, output int d);
		cyc(20);
		wr(`ASQ_SPC, ph);
		wr(`ASQ_PSSI, 32'h1);
		d = 0;
		while (!conv_start && d < 300) begin
			@(posedge clk);
			d++;
		end
	endtask
	// Bounded wait for a number of conversion starts
	task automatic wait_n(input int n);
		int k;
		k = 0;
		while (starts.size() < n && k < 2000) begin
			@(posedge clk);
			k++;
		end
		chk(32'(starts.size() >= n), 32'h1);
	endtask
	task automatic ext_pulse();
		trig_ext_pin <= 1'h1;
		cyc(2);
		trig_ext_pin <= 1'h0;
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Watchdog far beyond the expected run length
	initial begin
		#100000;
		fail_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		end_of_test();
	end
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{rst_n, reg_wr, reg_rd, trig_ext_pin, global_sync_in, fixed} = 6'h0;
		{reg_addr, reg_wdata, core_lat, core_res} = 54'h0;
		seed = 32'h8FE12A07;
		{fail_count, samples_checked, gs_cnt} = 96'h0;
		dc_cnt = '{0, 0, 0, 0};
		cyc(2);
		rst_n <= 1'h1;
		rd(`ASQ_SSPRI);
		chk(v, {24'h0, `ASQ_PRI_RST});
		rd(`ASQ_STAT);
		chk(v, 32'h0);
		rd(8'hFC);
		chk(v, 32'h0);
		$display("test reset done");
		for (int r = 0; r < 4; r++) begin
			wr(`ASQ_CTL, r);
			cyc(2);
			chk({ref_ext_third, ref_ext_full}, {r == 1, r == 3});
		end
		$display("test reference done");
		wr(`ASQ_ACTSS, 32'hF);
		wr(`ASQ_SSLEN, 32'hE00);
		wr(`ASQ_DCTHR, 32'h0);
		wr(`ASQ_DCSTEP, 32'h8000);
		for (int t = 0; t < 6; t++) begin
			pri = (t == 0) ? 8'h63 : (t == 1) ? 8'h9C : seed[7:0];
			wr(`ASQ_SSPRI, {24'h0, pri});
			p = 4'hE;
			repeat (3) begin
				s = pick(p, pri);
				exp_q.push_back(s);
				p[s] = 1'h0;
			end
			base = starts.size();
			wr(`ASQ_PSSI, 32'hE);
			wait_n(base + 3);
			cyc(20);
			chk(starts.size(), base + 3);
			for (int k = 0; k < 3; k++) chk(starts[base + k], exp_q[k]);
			exp_q.delete();
		end
		chk(dc_cnt[3], 32'h0);
		$display("test arbitration done");
		fixed <= 1'h1;
		wr(`ASQ_DCTHR, 32'h800);
		for (int t = 1; t < 3; t++) begin
			wr(`ASQ_SSLEN, t);
			wr(`ASQ_DCSTEP, 32'h9);
			base = starts.size();
			wr(`ASQ_PSSI, 32'h1);
			wait_n(base + t + 1);
			cyc(20);
			chk(dc_cnt[0], t - 1);
		end
		rd(`ASQ_RIS);
		chk(v & 32'h10, 32'h10);
		fixed <= 1'h0;
		$display("test comparator done");
		wr(`ASQ_DCSTEP, 32'h0);
		wr(`ASQ_SSLEN, 32'h0);
		base = starts.size();
		wr(`ASQ_PSSI, (32'h1 << `ASQ_PSSI_SWAIT) | 32'h1);
		cyc(10);
		chk(starts.size(), base);
		rd(`ASQ_PSSI);
		chk(v, 32'h1);
		global_sync_in <= 1'h1;
		cyc(4);
		global_sync_in <= 1'h0;
		wait_n(base + 1);
		wr(`ASQ_PSSI, 32'h1 << `ASQ_PSSI_GLOBAL_SYNC);
		cyc(2);
		chk(gs_cnt, 32'h1);
		$display("test sync done");
		// The offset adds exactly its own count of cycles after this sequencer's trigger
		lat_of(32'h0, d0);
		lat_of(32'h9, d1);
		chk(d1 - d0, 32'h9);
		wr(`ASQ_SPC, 32'h0);
		$display("test phase done");
		cyc(20);
		rd(`ASQ_RIS);
		wr(`ASQ_IM, 32'h1);
		base = starts.size();
		wr(`ASQ_PSSI, 32'h1);
		wait_n(base + 1);
		cyc(10);
		chk(irq, 1'h1);
		wr(`ASQ_IM, 32'h0);
		cyc(2);
		chk(irq, 1'h0);
		wr(`ASQ_IM, 32'h1);
		cyc(2);
		chk(irq, 1'h1);
		rd(`ASQ_RIS);
		chk(v & 32'h1, 32'h1);
		cyc(2);
		chk(irq, 1'h0);
		$display("test interrupt done");
		wr(`ASQ_IM, 32'h0);
		wr(`ASQ_EMUX, 32'h4);
		wr(`ASQ_SSLEN, 32'h3);
		wr(`ASQ_IESTEP, 32'h3);
		base = starts.size();
		ext_pulse();
		wait_n(base + 1);
		ext_pulse();
		cyc(4);
		rd(`ASQ_STAT);
		chk(v & 32'h100, 32'h100);
		wait_n(base + 12);
		rd(`ASQ_RIS);
		chk(v & 32'h1, 32'h1);
		base = starts.size();
		wait_n(base + 5);
		rd(`ASQ_RIS);
		chk(v & 32'h1, 32'h1);
		chk(irq, 1'h0);
		rst_n <= 1'h0;
		cyc(2);
		rst_n <= 1'h1;
		rd(`ASQ_STAT);
		chk(v, 32'h0);
		base = starts.size();
		cyc(30);
		chk(starts.size(), base);
		$display("test continuous done");
		// Processor run on the first, external run queued behind it on the second
		wr(`ASQ_ACTSS, 32'h3);
		wr(`ASQ_EMUX, 32'h40);
		wr(`ASQ_SPC, 32'h14);
		wr(`ASQ_PSSI, 32'h1);
		ext_pulse();
		wait_n(base + 2);
		cyc(20);
		rd(`ASQ_RIS);
		chk(v & 32'h3, 32'h2);
		$display("test lost event done");
		end_of_test();
	end
endmodule // asq_ctrl_tb_top

// file: hdl/asq_cfg.svh
// Offsets, field positions, encodings and reset values of the sequencer control block
`ifndef ASQ_CFG_SVH
`define ASQ_CFG_SVH
`define ASQ_CTL 8'h00
`define ASQ_ACTSS 8'h04
`define ASQ_EMUX 8'h08
`define ASQ_SSPRI 8'h0C
`define ASQ_PSSI 8'h10
`define ASQ_SPC 8'h14
`define ASQ_RIS 8'h18
`define ASQ_IM 8'h1C
`define ASQ_SSLEN 8'h20
`define ASQ_IESTEP 8'h24
`define ASQ_DCSTEP 8'h28
`define ASQ_DCTHR 8'h2C
`define ASQ_STAT 8'h30
`define ASQ_VREF_FULL 2'h3
`define ASQ_VREF_THIRD 2'h1
`define ASQ_TRG_PROC 4'h0
`define ASQ_TRG_COMP 4'h1
`define ASQ_TRG_EXT 4'h4
`define ASQ_TRG_TIMER 4'h5
`define ASQ_TRG_PWM 4'h6
`define ASQ_TRG_ALWAYS 4'hF
`define ASQ_PSSI_GLOBAL_SYNC 31
`define ASQ_PSSI_SWAIT 27
`define ASQ_SEQ3_LAST 3'h0
`define ASQ_PRI_RST 8'hE4
`endif

// file: hdl/asq_ctrl.sv
// Sequencer control: triggers, arbitration, comparators and phase offset for a converter core
//
// Operation
// - Reference field value 3 selects full external reference, value 1 one third of it.
// - Same-type retrigger of a running sequencer makes it sample continuously.
// - Continuous sampling still raises step interrupts on every pass.
// - Comparator on final step gives no trigger or interrupt for listed trigger sources.
// - Fourth sequencer holds exactly one step.
// - Result of step n goes to comparator of step n+1, with its configuration.
// - Processor sequence event is lost when a different-source sequence follows directly.
// - With third and fourth pending, arbiter compares second and third priorities instead.
// - Priorities 0,1,2 on second,fourth,third: third runs right after second.
// - Priorities 3,2,1 on second,fourth,third: order fourth, third, second.
// - Phase offset counts from each sequencer's own trigger instant.
// - Processor initiate offers global-sync and sync-wait bits to start modules together.
// - Always-trigger starts leave phase offsets between modules unaligned.
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "asq_cfg.svh"
module asq_ctrl import asq_pkg::*; #(
	parameter int PHASE_W = 8
) (
	input logic clk,
	input logic rst_n,
	input logic [7:0] reg_addr,
	input logic [31:0] reg_wdata,
	input logic reg_wr,
	input logic reg_rd,
	output logic [31:0] reg_rdata,
	input logic trig_comp_pin,
	input logic trig_ext_pin,
	input logic trig_timer_pin,
	input logic trig_pwm_pin,
	input logic global_sync_in,
	output logic global_sync_out,
	output logic conv_start,
	output asq_conv_s conv_req,
	input logic conv_done,
	input logic [11:0] conv_result,
	output logic ref_ext_full,
	output logic ref_ext_third,
	output logic [3:0] dc_trig,
	output logic irq
);
	logic [1:0] vref_q, cur_q, win, c23;
	logic [3:0] actss_q, pend_q, act_q, cont_q, hold_q, def_q;
	logic [3:0] hit, proc_go, nt, retrig, seq_set, dc_set, cur_oh;
	logic [15:0] emux_q, dcstep_q, ptype_q, ctype_q, ntype;
	logic [7:0] pri_q, ris_q, im_q, ris_d;
	logic [11:0] len_q, iestep_q, dcthr_q;
	logic [PHASE_W-1:0] spc_q, ph_q;
	logic [4:0] s1_q, s2_q, s3_q, rise;
	logic [2:0] step_q, dstep;
	logic [3:0] cur_ctype, dcf;
	asq_state_e st_q;
	logic pssi_wr, sync_rel, grant, done_last, ie_hit, drop, dc_eval, dc_supp;

	function automatic logic [3:0] nib(input logic [15:0] v, input logic [1:0] s);
		nib = v[{s, 2'b00} +: 4];
	endfunction
	function automatic logic [2:0] tri3(input logic [11:0] v, input logic [1:0] s);
		tri3 = v[int'(s) * 3 +: 3];
	endfunction
	function automatic logic [2:0] last_of(input logic [11:0] v, input logic [1:0] s);
		last_of = (s == 2'h3) ? `ASQ_SEQ3_LAST : tri3(v, s);
	endfunction
	function automatic logic [1:0] pri_of(input logic [7:0] v, input logic [1:0] s);
		pri_of = v[{s, 1'b0} +: 2];
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pin triggers and the partner's sync pass two flops before any edge logic
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= 5'h00;
			s2_q <= 5'h00;
			s3_q <= 5'h00;
		end else begin
			s1_q <= {global_sync_in, trig_pwm_pin, trig_timer_pin, trig_ext_pin,
				trig_comp_pin};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	assign rise = s2_q & ~s3_q;

	////////////////////////////////////////////////////////////////////////////////
	// Software registers; the reference decode is held in flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vref_q <= 2'h0;
			ref_ext_full <= 1'b0;
			ref_ext_third <= 1'b0;
			actss_q <= 4'h0;
			emux_q <= 16'h0000;
			pri_q <= `ASQ_PRI_RST;
			spc_q <= '0;
			im_q <= 8'h00;
			len_q <= 12'h000;
			iestep_q <= 12'h000;
			dcstep_q <= 16'h0000;
			dcthr_q <= 12'h000;
		end else if (reg_wr) begin
			case (reg_addr)
				`ASQ_CTL: begin
					vref_q <= reg_wdata[1:0];
					ref_ext_full <= reg_wdata[1:0] == `ASQ_VREF_FULL;
					ref_ext_third <= reg_wdata[1:0] == `ASQ_VREF_THIRD;
				end
				`ASQ_ACTSS: actss_q <= reg_wdata[3:0];
				`ASQ_EMUX: emux_q <= reg_wdata[15:0];
				`ASQ_SSPRI: pri_q <= reg_wdata[7:0];
				`ASQ_SPC: spc_q <= reg_wdata[PHASE_W-1:0];
				`ASQ_IM: im_q <= reg_wdata[7:0];
				`ASQ_SSLEN: len_q <= reg_wdata[11:0];
				`ASQ_IESTEP: iestep_q <= reg_wdata[11:0];
				`ASQ_DCSTEP: dcstep_q <= reg_wdata[15:0];
				`ASQ_DCTHR: dcthr_q <= reg_wdata[11:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Processor initiate: a sync-wait request is parked until a global sync
	assign pssi_wr = reg_wr && reg_addr == `ASQ_PSSI;
	assign sync_rel = (pssi_wr && reg_wdata[`ASQ_PSSI_GLOBAL_SYNC]) || rise[4];
	always_comb begin
		proc_go = sync_rel ? hold_q : 4'h0;
		if (pssi_wr && (!reg_wdata[`ASQ_PSSI_SWAIT] || reg_wdata[`ASQ_PSSI_GLOBAL_SYNC]))
			proc_go = proc_go | reg_wdata[3:0];
		proc_go = proc_go & actss_q;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_q <= 4'h0;
			global_sync_out <= 1'b0;
		end else begin
			global_sync_out <= pssi_wr && reg_wdata[`ASQ_PSSI_GLOBAL_SYNC];
			if (pssi_wr && reg_wdata[`ASQ_PSSI_SWAIT] && !reg_wdata[`ASQ_PSSI_GLOBAL_SYNC])
				hold_q <= (sync_rel ? 4'h0 : hold_q) | reg_wdata[3:0];
			else if (sync_rel)
				hold_q <= 4'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Trigger match per sequencer, and same-type retrigger detection
	always_comb begin
		for (int s = 0; s < 4; s++) begin
			case (nib(emux_q, 2'(s)))
				`ASQ_TRG_COMP: hit[s] = rise[0];
				`ASQ_TRG_EXT: hit[s] = rise[1];
				`ASQ_TRG_TIMER: hit[s] = rise[2];
				`ASQ_TRG_PWM: hit[s] = rise[3];
				`ASQ_TRG_ALWAYS: hit[s] = 1'b1;
				default: hit[s] = 1'b0;
			endcase
			hit[s] = hit[s] & actss_q[s];
			nt[s] = hit[s] | proc_go[s];
			ntype[s*4 +: 4] = proc_go[s] ? `ASQ_TRG_PROC : nib(emux_q, 2'(s));
			// Type-matched retrigger of a busy sequencer latches continuous mode
			retrig[s] = nt[s] & act_q[s] & (ntype[s*4 +: 4] == nib(ctype_q, 2'(s)));
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Faulty arbiter: the third/fourth contest uses the second's priority
	always_comb begin
		logic [1:0] bp;
		bp = 2'h3;
		win = 2'h0;
		if (pend_q[2] && pend_q[3])
			c23 = (pri_of(pri_q, 2'h1) < pri_of(pri_q, 2'h2)) ? 2'h2 : 2'h3;
		else
			c23 = pend_q[2] ? 2'h2 : 2'h3;
		if (pend_q[2] || pend_q[3]) begin
			win = c23;
			bp = pri_of(pri_q, c23);
		end
		// Lower index wins ties, so the first two are checked last with <=
		if (pend_q[1] && (!(pend_q[2] || pend_q[3]) || pri_of(pri_q, 2'h1) <= bp)) begin
			win = 2'h1;
			bp = pri_of(pri_q, 2'h1);
		end
		if (pend_q[0] && (pend_q[3:1] == 3'h0 || pri_of(pri_q, 2'h0) <= bp))
			win = 2'h0;
	end
	assign grant = st_q == ST_IDLE && pend_q != 4'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Pending, active and continuous flags; reset clears them all
	assign done_last = st_q == ST_CONV && conv_done && step_q == last_of(len_q, cur_q);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_q <= 4'h0;
			cont_q <= 4'h0;
			act_q <= 4'h0;
			ptype_q <= 16'h0000;
			ctype_q <= 16'h0000;
		end else begin
			for (int s = 0; s < 4; s++) begin
				if (grant && win == 2'(s)) begin
					pend_q[s] <= 1'b0;
					act_q[s] <= 1'b1;
					ctype_q[s*4 +: 4] <= ptype_q[s*4 +: 4];
				end else if (done_last && cur_q == 2'(s) && !cont_q[s])
					act_q[s] <= 1'b0;
				// A new trigger wins over the grant that clears the flag
				if (nt[s] && !retrig[s]) begin
					pend_q[s] <= 1'b1;
					ptype_q[s*4 +: 4] <= ntype[s*4 +: 4];
				end
				if (!actss_q[s]) begin
					pend_q[s] <= 1'b0;
					cont_q[s] <= 1'b0;
				end else if (retrig[s])
					cont_q[s] <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequence walk: phase delay, then one conversion per step
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= ST_IDLE;
			cur_q <= 2'h0;
			step_q <= 3'h0;
			ph_q <= '0;
			conv_start <= 1'b0;
			conv_req <= '0;
		end else begin
			conv_start <= 1'b0;
			case (st_q)
				ST_IDLE: if (grant) begin
					cur_q <= win;
					step_q <= 3'h0;
					// Offset runs from this sequencer's own start, not a shared instant
					ph_q <= spc_q;
					st_q <= ST_PHASE;
				end
				ST_PHASE: if (ph_q == '0) begin
					conv_start <= 1'b1;
					conv_req <= {cur_q, step_q};
					st_q <= ST_CONV;
				end else
					ph_q <= ph_q - 1'b1;
				ST_CONV: if (conv_done) begin
					if (step_q == last_of(len_q, cur_q)) begin
						if (cont_q[cur_q]) begin
							step_q <= 3'h0;
							ph_q <= spc_q;
							st_q <= ST_PHASE;
						end else
							st_q <= ST_IDLE;
					end else begin
						step_q <= step_q + 3'h1;
						conv_start <= 1'b1;
						conv_req <= {cur_q, step_q + 3'h1};
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Step events and the shifted digital comparator
	assign cur_oh = 4'h1 << cur_q;
	assign cur_ctype = nib(ctype_q, cur_q);
	assign ie_hit = st_q == ST_CONV && conv_done && step_q == tri3(iestep_q, cur_q);
	assign dcf = nib(dcstep_q, cur_q);
	assign dstep = dcf[2:0];
	// Step n's result meets step n+1's comparator and threshold
	assign dc_eval = st_q == ST_CONV && conv_done && dcf[3]
		&& {1'b0, dstep} == {1'b0, step_q} + 4'h1;
	// Final-step comparator is dead unless the sequencer runs on always-trigger
	assign dc_supp = dstep == last_of(len_q, cur_q) && cur_ctype != `ASQ_TRG_ALWAYS;
	assign dc_set = (dc_eval && !dc_supp && conv_result >= dcthr_q) ? cur_oh : 4'h0;
	// Processor-run events wait a cycle and die if another source is granted then
	assign drop = grant && nib(ptype_q, win) != `ASQ_TRG_PROC;
	assign seq_set = ((ie_hit && cur_ctype != `ASQ_TRG_PROC) ? cur_oh : 4'h0)
		| (drop ? 4'h0 : def_q);
	assign ris_d = ((reg_rd && reg_addr == `ASQ_RIS) ? 8'h00 : ris_q) | {dc_set, seq_set};
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			def_q <= 4'h0;
			ris_q <= 8'h00;
			dc_trig <= 4'h0;
			irq <= 1'b0;
		end else begin
			def_q <= (ie_hit && cur_ctype == `ASQ_TRG_PROC) ? cur_oh : 4'h0;
			ris_q <= ris_d;
			dc_trig <= dc_set;
			irq <= (ris_d & im_q) != 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read port: data stand in the cycle after the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			reg_rdata <= 32'h0000_0000;
		else if (reg_rd) begin
			case (reg_addr)
				`ASQ_CTL: reg_rdata <= {30'h0, vref_q};
				`ASQ_ACTSS: reg_rdata <= {28'h0, actss_q};
				`ASQ_EMUX: reg_rdata <= {16'h0, emux_q};
				`ASQ_SSPRI: reg_rdata <= {24'h0, pri_q};
				`ASQ_PSSI: reg_rdata <= {28'h0, hold_q};
				`ASQ_SPC: reg_rdata <= {{(32-PHASE_W){1'b0}}, spc_q};
				`ASQ_RIS: reg_rdata <= {24'h0, ris_q};
				`ASQ_IM: reg_rdata <= {24'h0, im_q};
				`ASQ_SSLEN: reg_rdata <= {20'h0, `ASQ_SEQ3_LAST, len_q[8:0]};
				`ASQ_IESTEP: reg_rdata <= {20'h0, iestep_q};
				`ASQ_DCSTEP: reg_rdata <= {16'h0, dcstep_q};
				`ASQ_DCTHR: reg_rdata <= {20'h0, dcthr_q};
				`ASQ_STAT: reg_rdata <= {20'h0, cont_q, act_q, pend_q};
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end else
			reg_rdata <= 32'h0000_0000;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_vref;
		reg_wr && reg_addr == `ASQ_CTL && reg_wdata[1:0] == 2'h3 |=> ref_ext_full && !ref_ext_third;
	endproperty
	a_vref: assert property (p_vref) else $error("reference 3 not full");

	property p_cont;
		retrig != 4'h0 && (retrig & actss_q) == retrig |=> (cont_q & $past(retrig)) == $past(retrig);
	endproperty
	a_cont: assert property (p_cont) else $error("retrigger did not latch continuous");

	property p_pass;
		done_last && cont_q[cur_q] |=> st_q == ST_PHASE && step_q == 3'h0;
	endproperty
	a_pass: assert property (p_pass) else $error("continuous pass did not restart");

	property p_last;
		dc_eval && dc_supp |=> dc_trig == 4'h0 ##1 1'b1;
	endproperty
	a_last: assert property (p_last) else $error("final step comparator fired");

	property p_one;
		conv_start && conv_req.seq == 2'h3 |-> conv_req.step == 3'h0 ##1 st_q != ST_PHASE;
	endproperty
	a_one: assert property (p_one) else $error("fourth sequencer beyond one step");

	property p_shift;
		dc_eval && !dc_supp && conv_result >= dcthr_q |=> (dc_trig & ris_q[7:4]) == dc_trig
			&& dc_trig != 4'h0;
	endproperty
	a_shift: assert property (p_shift) else $error("shifted comparator missed");

	property p_arb;
		grant && pend_q == 4'hC && pri_q[3:2] < pri_q[5:4] |=> cur_q == 2'h2 ##1 st_q != ST_IDLE;
	endproperty
	a_arb: assert property (p_arb) else $error("arbiter not using second priority");

	property p_phase;
		grant |=> st_q == ST_PHASE && ph_q == $past(spc_q);
	endproperty
	a_phase: assert property (p_phase) else $error("phase not loaded at own start");
endmodule // asq_ctrl

// file: hdl/asq_pkg.sv
// Types shared by the sequencer control block
package asq_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_PHASE, ST_CONV} asq_state_e;
	typedef struct packed {
		logic [1:0] seq;
		logic [2:0] step;
	} asq_conv_s;
endpackage
